// [rtl/cad_pkg.sv]
package cad_pkg;

  localparam int unsigned CAD_DW       = 16;
  localparam int unsigned CAD_MW       = 17;
  localparam int unsigned CAD_NREG     = 16;
  localparam int unsigned CAD_RAW      = 4;
  localparam int unsigned CAD_DIV_BITS = 16;

  // processor_status_reg bit positions
  localparam int unsigned CAD_SR_C  = 0;
  localparam int unsigned CAD_SR_Z  = 1;
  localparam int unsigned CAD_SR_OV = 2;
  localparam int unsigned CAD_SR_N  = 3;
  localparam int unsigned CAD_SR_DC = 8;
  localparam logic [15:0] CAD_SR_RESET = 16'h0000;

  localparam logic [3:0] CAD_WREG_Q = 4'h0;
  localparam logic [3:0] CAD_WREG_R = 4'h1;

  typedef enum logic [4:0] {
    CAD_OP_NOP, CAD_OP_ADD, CAD_OP_ADDC, CAD_OP_SUB, CAD_OP_SUBB,
    CAD_OP_AND, CAD_OP_IOR, CAD_OP_XOR, CAD_OP_PASS,
    CAD_OP_SHIFT_A, CAD_OP_SHIFT_L,
    CAD_OP_MUL_SS, CAD_OP_MUL_UU, CAD_OP_MUL_US, CAD_OP_MUL_SU,
    CAD_OP_MUL_UB,
    CAD_OP_DIV_S32, CAD_OP_DIV_U32, CAD_OP_DIV_S16, CAD_OP_DIV_U16
  } cad_op_t;

  typedef enum logic [1:0] {
    CAD_SRC_WREG, CAD_SRC_MEM, CAD_SRC_LIT
  } cad_src_t;

  typedef struct packed {
    cad_op_t           op;
    logic              byte_mode;
    cad_src_t          src_a;
    cad_src_t          src_b;
    logic [3:0]        ra;
    logic [3:0]        rb;
    logic [15:0]       lit;
    logic              dst_mem;
    logic [3:0]        rd;
    logic [15:0]       mem_addr;
  } cad_cmd_t;

endpackage

// [rtl/cad_regfile.sv]
`timescale 1ns/1ps
module cad_regfile
  import cad_pkg::*;
#(
  parameter int unsigned NREG = CAD_NREG,
  parameter int unsigned DW   = CAD_DW
) (
  input  wire logic                    sys_clk_in,
  input  wire logic                    rst_b_in,
  input  wire logic [$clog2(NREG)-1:0] ra_in,
  input  wire logic [$clog2(NREG)-1:0] rb_in,
  input  wire logic [$clog2(NREG)-1:0] rc_in,
  output logic      [DW-1:0]           rd_a_out,
  output logic      [DW-1:0]           rd_b_out,
  output logic      [DW-1:0]           rd_c_out,
  input  wire logic                    we0_in,
  input  wire logic [$clog2(NREG)-1:0] wa0_in,
  input  wire logic [DW-1:0]           wd0_in,
  input  wire logic                    we1_in,
  input  wire logic [$clog2(NREG)-1:0] wa1_in,
  input  wire logic [DW-1:0]           wd1_in
);

  logic [DW-1:0] mem_q [NREG];

  // port 1 wins on a clash so a remainder is never lost behind a quotient
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++)
    begin : g_reg
      always_ff @(posedge sys_clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
          mem_q[gi] <= '0;
        else if (we1_in && wa1_in == gi)
          mem_q[gi] <= wd1_in;
        else if (we0_in && wa0_in == gi)
          mem_q[gi] <= wd0_in;
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rd_a_out <= '0;
      rd_b_out <= '0;
      rd_c_out <= '0;
    end
    else
    begin
      rd_a_out <= mem_q[ra_in];
      rd_b_out <= mem_q[rb_in];
      rd_c_out <= mem_q[rc_in];
    end
  end

endmodule

// [rtl/cad_divider.sv]
`timescale 1ns/1ps
module cad_divider
  import cad_pkg::*;
#(
  parameter int unsigned DW = CAD_DIV_BITS
) (
  input  wire logic            sys_clk_in,
  input  wire logic            rst_b_in,
  input  wire logic            start_in,
  input  wire logic            signed_in,
  input  wire logic [2*DW-1:0] dividend_in,
  input  wire logic [DW-1:0]   divisor_in,
  output logic                 busy_out,
  output logic                 done_out,
  output logic      [DW-1:0]   quot_out,
  output logic      [DW-1:0]   rem_out
);

  localparam int unsigned CW = $clog2(DW + 1);

  logic [2*DW-1:0] num_q;
  logic [DW:0]     rem_q;
  logic [DW-1:0]   den_q;
  logic [CW-1:0]   cnt_q;
  logic            qneg_q;
  logic            rneg_q;
  logic [DW:0]     trial;
  logic [DW:0]     shifted;
  logic [2*DW-1:0] mag_n;
  logic [DW-1:0]   mag_d;
  logic [DW-1:0]   q_fin;
  logic [DW-1:0]   r_fin;

  // restoring divide on magnitudes; upper quotient bits assumed zero (no overflow)
  assign shifted = {rem_q[DW-1:0], num_q[2*DW-1]};
  assign trial   = shifted - {1'b0, den_q};
  assign mag_n   = (signed_in && dividend_in[2*DW-1]) ? (~dividend_in + 1'b1) : dividend_in;
  assign mag_d   = (signed_in && divisor_in[DW-1]) ? (~divisor_in + 1'b1) : divisor_in;
  assign q_fin   = {num_q[DW-2:0], ~trial[DW]};
  assign r_fin   = trial[DW] ? shifted[DW-1:0] : trial[DW-1:0];

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      num_q    <= '0;
      rem_q    <= '0;
      den_q    <= '0;
      cnt_q    <= '0;
      qneg_q   <= 1'b0;
      rneg_q   <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      quot_out <= '0;
      rem_out  <= '0;
    end
    else
    begin
      done_out <= 1'b0;
      if (start_in && !busy_out)
      begin
        // high half seeds the partial remainder so only DW steps are needed
        rem_q    <= {1'b0, mag_n[2*DW-1:DW]};
        num_q    <= {mag_n[DW-1:0], {DW{1'b0}}};
        den_q    <= mag_d;
        qneg_q   <= signed_in && (dividend_in[2*DW-1] ^ divisor_in[DW-1]);
        rneg_q   <= signed_in && dividend_in[2*DW-1];
        cnt_q    <= CW'(DW);
        busy_out <= 1'b1;
      end
      else if (busy_out)
      begin
        // one quotient bit per cycle // see RULE12
        num_q <= {num_q[2*DW-2:0], ~trial[DW]};
        rem_q <= trial[DW] ? shifted : trial;
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == CW'(1))
        begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          quot_out <= qneg_q ? (~q_fin + 1'b1) : q_fin;
          rem_out  <= rneg_q ? (~r_fin + 1'b1) : r_fin;
        end
      end
    end
  end

endmodule

// [rtl/cad_datapath.sv]
// How it works
// RULE1 - 16-bit ALU does add, subtract, shifts and logic in two's complement.
// RULE2 - carry, zero, negative, overflow and digit-carry flags update per operation.
// RULE3 - on subtract, carry means no-borrow and digit-carry means no digit-borrow.
// RULE4 - each ALU operation runs at byte or word width as instruction selects; byte-mode right shifts shift all 16 bits, keep low byte.
// RULE5 - operands come from working registers or memory; results go to either.
// RULE6 - one 17x17 multiplier serves unsigned, signed and mixed-sign products.
// RULE7 - word multiply in ss, uu, us, su modes and by a five-bit literal.
// RULE8 - byte multiply takes two unsigned 8-bit operands.
// RULE9 - divider handles signed and unsigned 32/16 and 16/16.
// RULE10 - divide quotient lands in register zero and remainder in register one.
// RULE11 - divisor from any register; 32-bit dividend from aligned pair, odd is high.
// RULE12 - divider yields one bit per cycle, same cycle count for both sizes.
// RULE13 - shifter moves up to sixteen places right or left in one cycle; the 5-bit signed count gives sixteen left but only fifteen right.
// RULE14 - shifter source is a working register or a memory location.
// RULE15 - signed count: positive shifts right, negative left, zero leaves operand.
// RULE16 - multiplier operands get sign extension if signed, zero extension otherwise.
`timescale 1ns/1ps
module cad_datapath
  import cad_pkg::*;
#(
  parameter int unsigned DW = CAD_DW
) (
  input  wire logic                sys_clk_in,
  input  wire logic                rst_b_in,
  input  wire logic                issue_in,
  input  wire cad_cmd_t            cmd_in,
  input  wire logic [DW-1:0]       mem_rdata_in,
  output logic                     ready_out,
  output logic                     done_out,
  output logic                     mem_we_out,
  output logic      [15:0]         mem_addr_out,
  output logic      [DW-1:0]       mem_wdata_out,
  output logic      [15:0]         processor_status_reg_out,
  output logic      [2*DW-1:0]     result_out
);

  typedef enum logic [1:0] {
    CAD_ST_IDLE, CAD_ST_FETCH, CAD_ST_EXEC, CAD_ST_DIV
  } cad_state_t;

  cad_state_t      state_q;
  cad_cmd_t        cmd_q;
  logic [DW-1:0]   rf_a;
  logic [DW-1:0]   rf_b;
  logic [DW-1:0]   rf_c;
  logic            wr0_en;
  logic [3:0]      wr0_addr;
  logic [DW-1:0]   wr0_data;
  logic            wr1_en;
  logic [3:0]      wr1_addr;
  logic [DW-1:0]   wr1_data;
  logic            div_start;
  logic            div_busy;
  logic            div_done;
  logic [DW-1:0]   div_q;
  logic [DW-1:0]   div_r;
  logic [2*DW-1:0] div_num;
  logic            div_signed;

  logic [DW-1:0]   opa;
  logic [DW-1:0]   opb;
  logic [DW-1:0]   res;
  logic [2*DW-1:0] prod_res;
  logic [15:0]     sr_d;
  logic            is_mul;
  logic            is_div;
  logic            wr_pair;

  logic signed [CAD_MW-1:0]     mul_a;
  logic signed [CAD_MW-1:0]     mul_b;
  logic signed [2*CAD_MW-1:0]   mul_p;

  // rc reads the odd partner of the dividend pair
  cad_regfile #(
    .NREG (CAD_NREG),
    .DW   (DW)
  ) u_regfile (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .ra_in      (cmd_q.ra),
    .rb_in      (cmd_q.rb),
    .rc_in      ({cmd_q.ra[3:1], 1'b1}),
    .rd_a_out   (rf_a),
    .rd_b_out   (rf_b),
    .rd_c_out   (rf_c),
    .we0_in     (wr0_en),
    .wa0_in     (wr0_addr),
    .wd0_in     (wr0_data),
    .we1_in     (wr1_en),
    .wa1_in     (wr1_addr),
    .wd1_in     (wr1_data)
  );

  cad_divider #(
    .DW (CAD_DIV_BITS)
  ) u_divider (
    .sys_clk_in  (sys_clk_in),
    .rst_b_in    (rst_b_in),
    .start_in    (div_start),
    .signed_in   (div_signed),
    .dividend_in (div_num),
    .divisor_in  (rf_b),
    .busy_out    (div_busy),
    .done_out    (div_done),
    .quot_out    (div_q),
    .rem_out     (div_r)
  );

  assign is_mul = cmd_q.op inside {CAD_OP_MUL_SS, CAD_OP_MUL_UU, CAD_OP_MUL_US, CAD_OP_MUL_SU,
                                   CAD_OP_MUL_UB};
  assign is_div = cmd_q.op inside {CAD_OP_DIV_S32, CAD_OP_DIV_U32, CAD_OP_DIV_S16, CAD_OP_DIV_U16};

  // operand sources follow the addressing mode // see RULE5 // see RULE14
  always_comb
  begin
    case (cmd_q.src_a)
      CAD_SRC_MEM: opa = mem_rdata_in;
      CAD_SRC_LIT: opa = cmd_q.lit;
      default:     opa = rf_a;
    endcase
    case (cmd_q.src_b)
      CAD_SRC_MEM: opb = mem_rdata_in;
      CAD_SRC_LIT: opb = cmd_q.lit;
      default:     opb = rf_b;
    endcase
  end

  // dividend from an aligned pair, odd register high // see RULE11
  always_comb
  begin
    div_signed = cmd_q.op inside {CAD_OP_DIV_S32, CAD_OP_DIV_S16}; // see RULE9
    case (cmd_q.op)
      CAD_OP_DIV_S32,
      CAD_OP_DIV_U32: div_num = {rf_c, rf_a[DW-1:0] & {DW{1'b1}}};
      CAD_OP_DIV_S16: div_num = {{DW{rf_a[DW-1]}}, rf_a};
      default:        div_num = {{DW{1'b0}}, rf_a};
    endcase
  end

  // single 17x17 signed multiplier; each operand extended by its mode // see RULE6 // see RULE16
  always_comb
  begin
    case (cmd_q.op)
      CAD_OP_MUL_SS:
      begin
        mul_a = {opa[DW-1], opa};
        mul_b = {opb[DW-1], opb};
      end
      CAD_OP_MUL_SU:
      begin
        mul_a = {opa[DW-1], opa};
        mul_b = {1'b0, opb};
      end
      CAD_OP_MUL_US:
      begin
        mul_a = {1'b0, opa};
        mul_b = {opb[DW-1], opb};
      end
      CAD_OP_MUL_UB:
      begin
        mul_a = {9'h000, opa[7:0]}; // see RULE8
        mul_b = {9'h000, opb[7:0]};
      end
      default:
      begin
        mul_a = {1'b0, opa};
        mul_b = {1'b0, opb};
      end
    endcase
    // a literal operand b carries only five unsigned bits, except in byte multiply // see RULE7
    if (cmd_q.src_b == CAD_SRC_LIT && !(cmd_q.op inside {CAD_OP_MUL_UB}))
      mul_b = {12'h000, cmd_q.lit[4:0]};
    mul_p    = mul_a * mul_b;
    prod_res = mul_p[2*DW-1:0];
  end

  // alu core with flag generation // see RULE1 // see RULE2
  always_comb
  begin
    logic [DW:0]   sum;
    logic [4:0]    nib;
    logic [DW-1:0] bsel;
    logic          cin;
    logic          sub;
    logic          msb;
    logic          cy;
    logic signed [4:0]  cnt;
    logic [4:0]    mag;
    logic [2*DW-1:0] ext;
    sum  = '0;
    nib  = '0;
    bsel = '0;
    cin  = 1'b0;
    sub  = 1'b0;
    msb  = 1'b0;
    cy   = 1'b0;
    cnt  = '0;
    mag  = '0;
    ext  = '0;
    res  = opa;
    sr_d = processor_status_reg_out;
    sub  = cmd_q.op inside {CAD_OP_SUB, CAD_OP_SUBB};
    // carry in for subtract is the inverted borrow // see RULE3
    case (cmd_q.op)
      CAD_OP_ADDC, CAD_OP_SUBB: cin = processor_status_reg_out[CAD_SR_C];
      CAD_OP_SUB:               cin = 1'b1;
      default:                  cin = 1'b0;
    endcase
    bsel = sub ? ~opb : opb;
    if (cmd_q.byte_mode) // see RULE4
    begin
      sum = {8'h00, {1'b0, opa[7:0]} + {1'b0, bsel[7:0]} + {8'h00, cin}};
      cy  = sum[8];
      msb = sum[7];
    end
    else
    begin
      sum = {1'b0, opa} + {1'b0, bsel} + {{DW{1'b0}}, cin};
      cy  = sum[DW];
      msb = sum[DW-1];
    end
    nib = {1'b0, opa[3:0]} + {1'b0, bsel[3:0]} + {4'h0, cin};
    case (cmd_q.op)
      CAD_OP_ADD, CAD_OP_ADDC, CAD_OP_SUB, CAD_OP_SUBB:
      begin
        res = sum[DW-1:0];
        sr_d[CAD_SR_C]  = cy;
        sr_d[CAD_SR_DC] = nib[4];
        sr_d[CAD_SR_OV] = cmd_q.byte_mode ? ((opa[7] == bsel[7]) && (msb != opa[7]))
                                          : ((opa[DW-1] == bsel[DW-1]) && (msb != opa[DW-1]));
      end
      CAD_OP_AND:  res = opa & opb;
      CAD_OP_IOR:  res = opa | opb;
      CAD_OP_XOR:  res = opa ^ opb;
      CAD_OP_SHIFT_A, CAD_OP_SHIFT_L:
      begin
        // signed count: positive right, negative left, zero passes // see RULE15 // see RULE13
        cnt = opb[4:0];
        mag = cnt[4] ? 5'(-cnt) : 5'(cnt);
        if (cnt == 5'sd0)
          res = opa;
        else if (cnt[4])
          res = DW'({16'h0000, opa} << mag);
        else
        begin
          ext = (cmd_q.op == CAD_OP_SHIFT_A) ? {{DW{opa[DW-1]}}, opa} : {{DW{1'b0}}, opa};
          res = DW'(ext >> mag);
        end
      end
      CAD_OP_PASS: res = opa;
      default:     res = opa;
    endcase
    if (cmd_q.byte_mode)
      res = {opa[DW-1:8], res[7:0]};
    if (!is_mul && !is_div && cmd_q.op != CAD_OP_NOP)
    begin
      sr_d[CAD_SR_Z] = cmd_q.byte_mode ? (res[7:0] == 8'h00) : (res == '0);
      sr_d[CAD_SR_N] = cmd_q.byte_mode ? res[7] : res[DW-1];
    end
  end

  // command sequencing
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_q   <= CAD_ST_IDLE;
      cmd_q     <= '0;
      ready_out <= 1'b1;
      div_start <= 1'b0;
    end
    else
    begin
      div_start <= 1'b0;
      case (state_q)
        CAD_ST_IDLE:
          if (issue_in)
          begin
            cmd_q     <= cmd_in;
            ready_out <= 1'b0;
            state_q   <= CAD_ST_FETCH;
          end
        CAD_ST_FETCH:
          if (is_div)
          begin
            div_start <= 1'b1;
            state_q   <= CAD_ST_DIV;
          end
          else
            state_q <= CAD_ST_EXEC;
        CAD_ST_EXEC:
        begin
          ready_out <= 1'b1;
          state_q   <= CAD_ST_IDLE;
        end
        CAD_ST_DIV:
          if (div_done)
          begin
            ready_out <= 1'b1;
            state_q   <= CAD_ST_IDLE;
          end
        default: state_q <= CAD_ST_IDLE;
      endcase
    end
  end

  // result steering: register or memory destination // see RULE5
  assign wr_pair  = (state_q == CAD_ST_EXEC) && is_mul && !cmd_q.dst_mem;
  assign wr0_en   = (state_q == CAD_ST_DIV && div_done) ||
                    (state_q == CAD_ST_EXEC && !cmd_q.dst_mem && cmd_q.op != CAD_OP_NOP);
  assign wr0_addr = (state_q == CAD_ST_DIV) ? CAD_WREG_Q : cmd_q.rd; // see RULE10
  assign wr0_data = (state_q == CAD_ST_DIV) ? div_q : (is_mul ? prod_res[DW-1:0] : res);
  assign wr1_en   = (state_q == CAD_ST_DIV && div_done) || wr_pair;
  assign wr1_addr = (state_q == CAD_ST_DIV) ? CAD_WREG_R : {cmd_q.rd[3:1], 1'b1};
  assign wr1_data = (state_q == CAD_ST_DIV) ? div_r : prod_res[2*DW-1:DW];

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      done_out                 <= 1'b0;
      mem_we_out               <= 1'b0;
      mem_addr_out             <= '0;
      mem_wdata_out            <= '0;
      result_out               <= '0;
      processor_status_reg_out <= CAD_SR_RESET;
    end
    else
    begin
      done_out   <= 1'b0;
      mem_we_out <= 1'b0;
      if (state_q == CAD_ST_IDLE && issue_in)
        mem_addr_out <= cmd_in.mem_addr;
      if (state_q == CAD_ST_EXEC)
      begin
        done_out                 <= 1'b1;
        processor_status_reg_out <= sr_d;
        result_out               <= is_mul ? prod_res : {{DW{1'b0}}, res};
        mem_we_out               <= cmd_q.dst_mem && cmd_q.op != CAD_OP_NOP;
        mem_wdata_out            <= is_mul ? prod_res[DW-1:0] : res;
      end
      else if (state_q == CAD_ST_DIV && div_done)
      begin
        done_out   <= 1'b1;
        result_out <= {div_r, div_q};
      end
    end
  end

endmodule

// [sim/cad_mem_model.sv]
`timescale 1ns/1ps
module cad_mem_model (
  input  wire logic        sys_clk_in,
  input  wire logic        we_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] wdata_in,
  output logic      [15:0] rdata_out
);
  logic [15:0] mem [0:255];
  // combinational read: the datapath holds the address from issue to done
  assign rdata_out = mem[addr_in[7:0]];
  // plain always so the bench may also preload words between operations
  always @(posedge sys_clk_in)
  begin
    if (we_in)
    begin
      mem[addr_in[7:0]] <= wdata_in;
    end
  end
endmodule

// [sim/cad_datapath_sva.sv]
`timescale 1ns/1ps
module cad_datapath_sva
  import cad_pkg::*;
#(
  parameter int unsigned DW = CAD_DW
) (
  input wire logic            sys_clk_in,
  input wire logic            rst_b_in,
  input wire logic            issue_in,
  input wire cad_cmd_t        cmd_in,
  input wire logic [DW-1:0]   mem_rdata_in,
  input wire logic            ready_out,
  input wire logic            done_out,
  input wire logic            mem_we_out,
  input wire logic [15:0]     mem_addr_out,
  input wire logic [DW-1:0]   mem_wdata_out,
  input wire logic [15:0]     processor_status_reg_out,
  input wire logic [2*DW-1:0] result_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  logic take;
  logic is_div;
  logic is_mul;
  assign take   = issue_in && ready_out;
  assign is_div = cmd_in.op inside {CAD_OP_DIV_S32, CAD_OP_DIV_U32, CAD_OP_DIV_S16, CAD_OP_DIV_U16};
  assign is_mul = cmd_in.op inside {CAD_OP_MUL_SS, CAD_OP_MUL_UU, CAD_OP_MUL_US, CAD_OP_MUL_SU, CAD_OP_MUL_UB};

  a_alu_latency: assert property (take && !is_div |=> !done_out ##1 !done_out ##1 done_out)
    else $error("alu op did not finish three cycles after issue");
  a_div_cycles: assert property (take && is_div |-> ##20 done_out)
    else $error("divide did not finish twenty cycles after issue");
  a_div_quiet: assert property (take && is_div |=> (!done_out && !ready_out) [*8])
    else $error("divide finished or went idle early");
  a_done_ready: assert property (done_out |-> ready_out && !$past(ready_out))
    else $error("done without a busy period before it");
  a_we_done: assert property (mem_we_out |-> done_out)
    else $error("memory write outside completion");
  a_result_hold: assert property ($changed(result_out) |-> done_out)
    else $error("result changed outside completion");
  a_flag_hold: assert property ($changed(processor_status_reg_out) |-> done_out)
    else $error("status changed outside completion");
  a_mul_flags: assert property (take && is_mul |-> ##3 $stable(processor_status_reg_out))
    else $error("multiply changed the status flags");
  a_addr_latch: assert property (take |=> mem_addr_out == $past(cmd_in.mem_addr))
    else $error("memory address not taken at issue");

  c_divide: cover property (take && is_div);
  c_mem_write: cover property (mem_we_out);
  c_shift: cover property (take && cmd_in.op == CAD_OP_SHIFT_L);
endmodule

bind cad_datapath cad_datapath_sva #(.DW(DW)) cad_datapath_sva_i (
  .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .issue_in(issue_in), .cmd_in(cmd_in),
  .mem_rdata_in(mem_rdata_in), .ready_out(ready_out), .done_out(done_out), .mem_we_out(mem_we_out),
  .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
  .processor_status_reg_out(processor_status_reg_out), .result_out(result_out));

// [sim/cad_datapath_tb.sv]
`timescale 1ns/1ps
module cad_datapath_tb
  import cad_pkg::*;
;
  typedef struct {
    cad_op_t     op;
    logic [1:0]  md;
    logic [15:0] a, b, c;
    logic [31:0] exp;
    logic [15:0] sr, msk;
  } cad_row_t;
  logic        clk;
  logic        rst_b;
  logic        issue;
  cad_cmd_t    cmd;
  cad_cmd_t    c;
  logic [15:0] rdata, maddr, wdata, sr;
  logic        ready, done, we, dv;
  logic [31:0] res;
  int          err_total, checks, n;
  // md bit0 selects byte width, bit1 takes operand b as a literal
  cad_row_t rows [28] = '{
    '{CAD_OP_ADD, 2'h0, 16'h7fff, 16'h1, 16'h0, 32'h8000, 16'h10c, 16'h10f},
    '{CAD_OP_ADD, 2'h0, 16'hffff, 16'h1, 16'h0, 32'h0, 16'h103, 16'h10f},
    '{CAD_OP_ADDC, 2'h0, 16'h1, 16'h2, 16'h0, 32'h4, 16'h0, 16'h10f},
    '{CAD_OP_SUB, 2'h0, 16'h5, 16'h7, 16'h0, 32'hfffe, 16'h8, 16'h10f},
    '{CAD_OP_SUBB, 2'h0, 16'h5, 16'h2, 16'h0, 32'h2, 16'h101, 16'h10f},
    '{CAD_OP_SUB, 2'h0, 16'h7, 16'h5, 16'h0, 32'h2, 16'h101, 16'h10f},
    '{CAD_OP_SUB, 2'h0, 16'h8000, 16'h1, 16'h0, 32'h7fff, 16'h5, 16'h10f},
    '{CAD_OP_ADD, 2'h1, 16'h12ff, 16'h1, 16'h0, 32'h1200, 16'h103, 16'h10f},
    '{CAD_OP_AND, 2'h0, 16'hf0f0, 16'hff0, 16'h0, 32'hf0, 16'h0, 16'ha},
    '{CAD_OP_IOR, 2'h0, 16'h1200, 16'h34, 16'h0, 32'h1234, 16'h0, 16'ha},
    '{CAD_OP_XOR, 2'h0, 16'haaaa, 16'haaaa, 16'h0, 32'h0, 16'h2, 16'ha},
    '{CAD_OP_SHIFT_A, 2'h0, 16'h8000, 16'h4, 16'h0, 32'hf800, 16'h0, 16'h0},
    '{CAD_OP_SHIFT_L, 2'h0, 16'h8000, 16'h4, 16'h0, 32'h800, 16'h0, 16'h0},
    '{CAD_OP_SHIFT_L, 2'h0, 16'h1, 16'h1d, 16'h0, 32'h8, 16'h0, 16'h0},
    '{CAD_OP_SHIFT_A, 2'h0, 16'h8421, 16'h0, 16'h0, 32'h8421, 16'h0, 16'h0},
    '{CAD_OP_SHIFT_L, 2'h0, 16'hffff, 16'hf, 16'h0, 32'h1, 16'h0, 16'h0},
    '{CAD_OP_SHIFT_L, 2'h0, 16'hffff, 16'h10, 16'h0, 32'h0, 16'h0, 16'h0},
    '{CAD_OP_MUL_SS, 2'h0, 16'hffff, 16'h2, 16'h0, 32'hfffffffe, 16'h0, 16'h0},
    '{CAD_OP_MUL_UU, 2'h0, 16'hffff, 16'h2, 16'h0, 32'h1fffe, 16'h0, 16'h0},
    '{CAD_OP_MUL_US, 2'h0, 16'hfffe, 16'h3, 16'h0, 32'h2fffa, 16'h0, 16'h0},
    '{CAD_OP_MUL_SU, 2'h0, 16'hfffe, 16'h3, 16'h0, 32'hfffffffa, 16'h0, 16'h0},
    '{CAD_OP_MUL_UB, 2'h0, 16'h12ff, 16'h34ff, 16'h0, 32'hfe01, 16'h0, 16'h0},
    '{CAD_OP_MUL_SS, 2'h2, 16'hffff, 16'h1f, 16'h0, 32'hffffffe1, 16'h0, 16'h0},
    '{CAD_OP_MUL_UU, 2'h2, 16'hffff, 16'h1f, 16'h0, 32'h1effe1, 16'h0, 16'h0},
    '{CAD_OP_DIV_U32, 2'h0, 16'h0, 16'h3, 16'h1, 32'h15555, 16'h0, 16'h0},
    '{CAD_OP_DIV_S32, 2'h0, 16'hfff9, 16'h2, 16'hffff, 32'hfffffffd, 16'h0, 16'h0},
    '{CAD_OP_DIV_U16, 2'h0, 16'h64, 16'h7, 16'h0, 32'h2000e, 16'h0, 16'h0},
    '{CAD_OP_DIV_S16, 2'h0, 16'hff9c, 16'h7, 16'h0, 32'hfffefff2, 16'h0, 16'h0}
  };

  cad_datapath cad_datapath_i (
    .sys_clk_in(clk), .rst_b_in(rst_b), .issue_in(issue), .cmd_in(cmd), .mem_rdata_in(rdata),
    .ready_out(ready), .done_out(done), .mem_we_out(we), .mem_addr_out(maddr),
    .mem_wdata_out(wdata), .processor_status_reg_out(sr), .result_out(res));
  cad_mem_model cad_mem_model_i (
    .sys_clk_in(clk), .we_in(we), .addr_in(maddr), .wdata_in(wdata), .rdata_out(rdata));

  always #5 clk = ~clk;

  function automatic cad_cmd_t mk(cad_op_t op, cad_src_t sa, cad_src_t sb, logic [3:0] ra, logic [3:0] rb,
                                  logic [15:0] lit, logic dm, logic [3:0] rd, logic [15:0] ma);
    cad_cmd_t k;
    k = '0;
    k.op = op;
    k.src_a = sa;
    k.src_b = sb;
    k.ra = ra;
    k.rb = rb;
    k.lit = lit;
    k.dst_mem = dm;
    k.rd = rd;
    k.mem_addr = ma;
    return k;
  endfunction

  task automatic fail(input string s);
    err_total++;
    $display("mismatch t=%0t %s", $time, s);
  endtask

  task automatic chk_res(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("result %h expected %h", got, exp));
  endtask

  task automatic chk_sr(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] msk);
    checks++;
    if ((got & msk) !== (exp & msk)) fail($sformatf("status %h expected %h", got, exp));
  endtask

  task automatic wait_done();
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (done !== 1'h1 && n < 40);
    if (n >= 40) fail("no completion");
  endtask

  // issues right away, so a call just after a completion lands in the done cycle
  task automatic run(input cad_cmd_t k);
    issue <= 1'h1;
    cmd <= k;
    @(posedge clk);
    issue <= 1'h0;
    n = 0;
    wait_done();
  endtask

  task automatic load(input logic [3:0] r, input logic [15:0] v);
    cad_mem_model_i.mem[8'hf0] = v;
    run(mk(CAD_OP_PASS, CAD_SRC_MEM, CAD_SRC_MEM, 4'h0, 4'h0, 16'h0, 1'h0, r, 16'hf0));
  endtask

  task automatic results();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'h0;
    rst_b = 1'h0;
    issue = 1'h0;
    cmd = '0;
    err_total = 0;
    checks = 0;
    n = 0;
    repeat (12) @(posedge clk);
    #1;
    chk_res({29'h0, ready, done, we}, 32'h4);
    chk_res(res, 32'h0);
    rst_b <= 1'h1;
    @(posedge clk);
    #1;
    $display("test reset done");
    foreach (rows[i])
    begin
      load(4'h2, rows[i].a);
      load(4'h3, rows[i].c);
      load(4'h6, rows[i].b);
      c = mk(rows[i].op, CAD_SRC_WREG, rows[i].md[1] ? CAD_SRC_LIT : CAD_SRC_WREG, 4'h2, 4'h6, rows[i].b,
             1'h0, 4'h4, 16'h0);
      c.byte_mode = rows[i].md[0];
      run(c);
      dv = rows[i].op inside {CAD_OP_DIV_S32, CAD_OP_DIV_U32, CAD_OP_DIV_S16, CAD_OP_DIV_U16};
      chk_res(res, rows[i].exp);
      chk_sr(sr, rows[i].sr, rows[i].msk);
      chk_res(32'(n), dv ? 32'h13 : 32'h2);
      if (dv)
      begin
        run(mk(CAD_OP_PASS, CAD_SRC_WREG, CAD_SRC_WREG, 4'h0, 4'h0, 16'h0, 1'h0, 4'h8, 16'h0));
        chk_res(res, {16'h0, rows[i].exp[15:0]});
        run(mk(CAD_OP_PASS, CAD_SRC_WREG, CAD_SRC_WREG, 4'h1, 4'h1, 16'h0, 1'h0, 4'h8, 16'h0));
        chk_res(res, {16'h0, rows[i].exp[31:16]});
      end
    end
    $display("test table done");
    // an add offered mid-divide must vanish without a trace
    issue <= 1'h1;
    cmd <= mk(CAD_OP_DIV_U16, CAD_SRC_WREG, CAD_SRC_WREG, 4'h2, 4'h6, 16'h0, 1'h0, 4'h4, 16'h0);
    @(posedge clk);
    issue <= 1'h0;
    repeat (3) @(posedge clk);
    issue <= 1'h1;
    cmd <= mk(CAD_OP_ADD, CAD_SRC_WREG, CAD_SRC_WREG, 4'h2, 4'h6, 16'h0, 1'h0, 4'h4, 16'h0);
    @(posedge clk);
    issue <= 1'h0;
    n = 4;
    wait_done();
    chk_res(res, 32'h2484);
    repeat (5)
    begin
      @(posedge clk);
      #1;
      chk_res({31'h0, done}, 32'h0);
    end
    $display("test refused issue done");
    cad_mem_model_i.mem[8'h20] = 16'hf0;
    run(mk(CAD_OP_SHIFT_L, CAD_SRC_MEM, CAD_SRC_LIT, 4'h0, 4'h0, 16'h1e, 1'h1, 4'h0, 16'h20));
    chk_res(res, 32'h3c0);
    @(posedge clk);
    #1;
    chk_res({16'h0, cad_mem_model_i.mem[8'h20]}, 32'h3c0);
    $display("test memory operand done");
    issue <= 1'h1;
    cmd <= mk(CAD_OP_DIV_U32, CAD_SRC_WREG, CAD_SRC_WREG, 4'h2, 4'h6, 16'h0, 1'h0, 4'h4, 16'h0);
    @(posedge clk);
    issue <= 1'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'h0;
    @(posedge clk);
    #1;
    chk_res({29'h0, ready, done, we}, 32'h4);
    chk_res(res, 32'h0);
    rst_b <= 1'h1;
    @(posedge clk);
    #1;
    // registers come back zero, so the sum is zero with carry clear
    run(mk(CAD_OP_ADD, CAD_SRC_WREG, CAD_SRC_WREG, 4'h2, 4'h6, 16'h0, 1'h0, 4'h4, 16'h0));
    chk_sr(sr, 16'h2, 16'h3);
    $display("test mid-run reset done");
    results();
  end

  initial
  begin
    repeat (8000) @(posedge clk);
    fail("watchdog expired");
    results();
  end
endmodule
